// File: rtl/olc_regs.sv
`timescale 1ns/10ps
// Functional notes
// - slope held 16-bit, 10 uV/A per count, reset 0000h, range 0..16 mV/A; writes outside it are stored without clamping
// - slope and overvoltage writes take effect only after commit command
// - output target never below stored floor of the cycle before, in mV; floor resets 0000h
// - overvoltage threshold stored in mV, reset 076Ch (1900 mV)
// - undervoltage fault masked while ramping or disabled; threshold resets zero
// - over-temperature limit in degrees C, reset 007Dh, values up to 2000; larger writes are stored without clamping
// - all settings per page, two-byte read/write two's-complement words
module olc_regs import olc_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire olc_req_t req_in,
  input wire olc_meas_t [OLC_PAGES-1:0] meas_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  output logic cmd_ok_out,
  output logic [OLC_PAGES-1:0][15:0] target_out,
  output logic [OLC_PAGES-1:0] ov_fault_out,
  output logic [OLC_PAGES-1:0] uv_fault_out,
  output logic [OLC_PAGES-1:0] ot_fault_out,
  output logic [OLC_PAGES-1:0][15:0] active_slope_out,
  output logic [OLC_PAGES-1:0][15:0] active_ov_out
);

  olc_state_t s_reg;
  olc_state_t s_next;

  function automatic logic is_known(input logic [7:0] c);
    is_known = (c == OLC_CMD_SLOPE) || (c == OLC_CMD_FLOOR) || (c == OLC_CMD_OV) ||
               (c == OLC_CMD_UV) || (c == OLC_CMD_OT) || (c == OLC_CMD_COMMIT);
  endfunction

  function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.cmd_ok = 1'b0;
    if (req_in.wr) begin
      s_next.cmd_ok = is_known(req_in.cmd);
      unique case (req_in.cmd)
        OLC_CMD_SLOPE: s_next.page[req_in.page].slope = req_in.wdata;
        OLC_CMD_FLOOR: s_next.page[req_in.page].floor_mv = req_in.wdata;
        OLC_CMD_OV: s_next.page[req_in.page].ov = req_in.wdata;
        OLC_CMD_UV: s_next.page[req_in.page].uv = req_in.wdata;
        OLC_CMD_OT: s_next.page[req_in.page].ot = req_in.wdata;
        OLC_CMD_COMMIT: begin
          // commit moves staged slope and ov of the addressed page into use
          s_next.act[req_in.page].slope = s_reg.page[req_in.page].slope;
          s_next.act[req_in.page].ov = s_reg.page[req_in.page].ov;
        end
        default: s_next.cmd_ok = 1'b0;
      endcase
    end else if (req_in.rd) begin
      s_next.rvalid = 1'b1;
      s_next.cmd_ok = is_known(req_in.cmd) && (req_in.cmd != OLC_CMD_COMMIT);
      unique case (req_in.cmd)
        OLC_CMD_SLOPE: s_next.rdata = s_reg.page[req_in.page].slope;
        OLC_CMD_FLOOR: s_next.rdata = s_reg.page[req_in.page].floor_mv;
        OLC_CMD_OV: s_next.rdata = s_reg.page[req_in.page].ov;
        OLC_CMD_UV: s_next.rdata = s_reg.page[req_in.page].uv;
        OLC_CMD_OT: s_next.rdata = s_reg.page[req_in.page].ot;
        default: s_next.rdata = 16'h0000;
      endcase
    end
    for (int p = 0; p < OLC_PAGES; p++) begin
      // floor clamp uses the live floor; signed compare per two's-complement format
      s_next.target[p] = sgt(s_reg.page[p].floor_mv, meas_in[p].target_mv) ?
                         s_reg.page[p].floor_mv : meas_in[p].target_mv;
      s_next.ov_fault[p] = sgt(meas_in[p].vout_mv, s_reg.act[p].ov);
      s_next.ot_fault[p] = sgt(meas_in[p].temp_c, s_reg.page[p].ot);
      s_next.uv_fault[p] = meas_in[p].enabled && !meas_in[p].ramping &&
                           sgt(s_reg.page[p].uv, meas_in[p].vout_mv);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      for (int p = 0; p < OLC_PAGES; p++) begin
        s_reg.page[p] <= '{OLC_SLOPE_RST, OLC_FLOOR_RST, OLC_OV_RST, OLC_UV_RST, OLC_OT_RST};
        s_reg.act[p] <= '{OLC_SLOPE_RST, OLC_OV_RST};
        s_reg.target[p] <= OLC_TARGET_RST;
      end
      s_reg.rdata <= OLC_RDATA_RST;
      s_reg.rvalid <= 1'b0;
      s_reg.cmd_ok <= 1'b0;
      s_reg.ov_fault <= '0;
      s_reg.uv_fault <= '0;
      s_reg.ot_fault <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata_out = s_reg.rdata;
    rvalid_out = s_reg.rvalid;
    cmd_ok_out = s_reg.cmd_ok;
    target_out = s_reg.target;
    ov_fault_out = s_reg.ov_fault;
    uv_fault_out = s_reg.uv_fault;
    ot_fault_out = s_reg.ot_fault;
    for (int p = 0; p < OLC_PAGES; p++) begin
      active_slope_out[p] = s_reg.act[p].slope;
      active_ov_out[p] = s_reg.act[p].ov;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions watch page 0; page 1 logic is the same loop body
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence ov_write_s;
    req_in.wr && req_in.cmd == OLC_CMD_OV && !req_in.page;
  endsequence

  sequence no_commit_s;
    !(req_in.wr && req_in.cmd == OLC_CMD_COMMIT && !req_in.page);
  endsequence

  sequence commit0_s;
    req_in.wr && req_in.cmd == OLC_CMD_COMMIT && !req_in.page;
  endsequence

  sequence commit1_s;
    req_in.wr && req_in.cmd == OLC_CMD_COMMIT && req_in.page;
  endsequence

  sequence slope_wr_s;
    req_in.wr && req_in.cmd == OLC_CMD_SLOPE && !req_in.page;
  endsequence

  sequence slope_rd_s;
    req_in.rd && !req_in.wr && req_in.cmd == OLC_CMD_SLOPE && !req_in.page;
  endsequence

  sequence read_s;
    req_in.rd && !req_in.wr;
  endsequence

  // committed values move only on a commit of their own page
  ov_hold_a: assert property ((ov_write_s and no_commit_s)
    |=> $stable(active_ov_out[0]))
    else $error("active ov changed without commit");
  slope_hold_a: assert property (no_commit_s
    |=> $stable(active_slope_out[0]))
    else $error("active slope changed without commit");
  commit_apply_a: assert property (commit0_s
    |=> active_slope_out[0] == $past(s_reg.page[0].slope))
    else $error("commit did not load slope");
  commit_ov_a: assert property (commit0_s
    |=> active_ov_out[0] == $past(s_reg.page[0].ov))
    else $error("commit did not load ov");
  commit_apart_a: assert property (commit1_s
    |=> $stable(active_ov_out[0]) && $stable(active_slope_out[0]))
    else $error("page 1 commit hit page 0");

  // answers to requests
  rvalid_pulse_a: assert property (read_s
    |=> rvalid_out)
    else $error("read gave no valid pulse");
  rvalid_idle_a: assert property ((!req_in.rd || req_in.wr)
    |=> !rvalid_out)
    else $error("valid pulse without read");
  rdata_hold_a: assert property ((!req_in.rd || req_in.wr)
    |=> $stable(rdata_out))
    else $error("read data moved without read");
  unknown_rd_a: assert property ((req_in.rd && !req_in.wr && !is_known(req_in.cmd))
    |=> rdata_out == 16'h0000 && !cmd_ok_out)
    else $error("unknown read not refused");
  unknown_wr_a: assert property ((req_in.wr && !is_known(req_in.cmd))
    |=> !cmd_ok_out && $stable(s_reg.page))
    else $error("unknown write not refused");
  slope_store_a: assert property (slope_wr_s ##1 slope_rd_s
    |=> rdata_out == $past(req_in.wdata, 2))
    else $error("slope readback mismatch");

  // staged stores take the written word whole
  floor_store_a: assert property ((req_in.wr && req_in.cmd == OLC_CMD_FLOOR && !req_in.page)
    |=> s_reg.page[0].floor_mv == $past(req_in.wdata))
    else $error("floor write lost");
  ov_store_a: assert property (ov_write_s
    |=> s_reg.page[0].ov == $past(req_in.wdata))
    else $error("ov write lost");
  uv_store_a: assert property ((req_in.wr && req_in.cmd == OLC_CMD_UV && !req_in.page)
    |=> s_reg.page[0].uv == $past(req_in.wdata))
    else $error("uv write lost");
  ot_store_a: assert property ((req_in.wr && req_in.cmd == OLC_CMD_OT && !req_in.page)
    |=> s_reg.page[0].ot == $past(req_in.wdata))
    else $error("ot write lost");

  // target clamp
  floor_clamp_a: assert property (1'b1
    |=> !sgt($past(s_reg.page[0].floor_mv), target_out[0]))
    else $error("target below floor");
  floor_lift_a: assert property (sgt(s_reg.page[0].floor_mv, meas_in[0].target_mv)
    |=> target_out[0] == $past(s_reg.page[0].floor_mv))
    else $error("target not lifted to floor");
  floor_pass_a: assert property (!sgt(s_reg.page[0].floor_mv, meas_in[0].target_mv)
    |=> target_out[0] == $past(meas_in[0].target_mv))
    else $error("target changed above floor");

  // fault levels: ov and ot both directions, uv mask and flag only
  ov_flag_a: assert property (sgt(meas_in[0].vout_mv, active_ov_out[0])
    |=> ov_fault_out[0])
    else $error("ov fault missed");
  ov_quiet_a: assert property (!sgt(meas_in[0].vout_mv, active_ov_out[0])
    |=> !ov_fault_out[0])
    else $error("ov fault without cause");
  uv_mask_a: assert property ((meas_in[0].ramping || !meas_in[0].enabled)
    |=> !uv_fault_out[0])
    else $error("uv fault not masked");
  uv_flag_a: assert property ((meas_in[0].enabled && !meas_in[0].ramping
    && sgt(s_reg.page[0].uv, meas_in[0].vout_mv)) |=> uv_fault_out[0])
    else $error("uv fault missed");
  ot_flag_a: assert property (sgt(meas_in[0].temp_c, s_reg.page[0].ot)
    |=> ot_fault_out[0])
    else $error("ot fault missed");
  ot_quiet_a: assert property (!sgt(meas_in[0].temp_c, s_reg.page[0].ot)
    |=> !ot_fault_out[0])
    else $error("ot fault without cause");

  // paging and reset values
  page_apart_a: assert property ((req_in.wr && req_in.cmd == OLC_CMD_OT && req_in.page)
    |=> $stable(s_reg.page[0].ot))
    else $error("page 1 write hit page 0");
  ov_reset_a: assert property ($fell(reset_in)
    |-> active_ov_out[0] == OLC_OV_RST)
    else $error("ov reset value wrong");
  reset_vals_a: assert property ($fell(reset_in)
    |-> active_slope_out[0] == OLC_SLOPE_RST && s_reg.page[0].floor_mv == OLC_FLOOR_RST && s_reg.page[0].ot == OLC_OT_RST)
    else $error("reset values wrong");

endmodule

// File: rtl/olc_pkg.sv
package olc_pkg;
  localparam int OLC_PAGES = 2;
  localparam logic [7:0] OLC_CMD_SLOPE = 8'h28;
  localparam logic [7:0] OLC_CMD_FLOOR = 8'h2B;
  localparam logic [7:0] OLC_CMD_OV = 8'h40;
  localparam logic [7:0] OLC_CMD_UV = 8'h44;
  localparam logic [7:0] OLC_CMD_OT = 8'h4F;
  localparam logic [7:0] OLC_CMD_COMMIT = 8'h64;
  localparam logic [15:0] OLC_SLOPE_RST = 16'h0000;
  localparam logic [15:0] OLC_FLOOR_RST = 16'h0000;
  localparam logic [15:0] OLC_OV_RST = 16'h076C;
  localparam logic [15:0] OLC_UV_RST = 16'h0000;
  localparam logic [15:0] OLC_OT_RST = 16'h007D;
  localparam logic [15:0] OLC_TARGET_RST = 16'h0000;
  localparam logic [15:0] OLC_RDATA_RST = 16'h0000;
  localparam logic [15:0] OLC_SLOPE_MAX = 16'h0640;
  localparam logic [15:0] OLC_OT_MAX = 16'h07D0;

  typedef struct packed {
    logic [15:0] slope;
    logic [15:0] floor_mv;
    logic [15:0] ov;
    logic [15:0] uv;
    logic [15:0] ot;
  } olc_page_t;

  typedef struct packed {
    logic [15:0] slope;
    logic [15:0] ov;
  } olc_active_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic page;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } olc_req_t;

  typedef struct packed {
    logic ramping;
    logic enabled;
    logic [15:0] vout_mv;
    logic [15:0] temp_c;
    logic [15:0] target_mv;
  } olc_meas_t;

  typedef struct packed {
    olc_page_t [OLC_PAGES-1:0] page;
    olc_active_t [OLC_PAGES-1:0] act;
    logic [15:0] rdata;
    logic rvalid;
    logic cmd_ok;
    logic [OLC_PAGES-1:0] ov_fault;
    logic [OLC_PAGES-1:0] uv_fault;
    logic [OLC_PAGES-1:0] ot_fault;
    logic [OLC_PAGES-1:0][15:0] target;
  } olc_state_t;
endpackage

// File: verif/olc_host_model.sv
`timescale 1ns/10ps
module olc_host_model import olc_pkg::*; (
  input wire logic sys_clk_in,
  output olc_req_t req_out
);
  initial req_out = '0;
  // one whole word per request; byte pairing belongs to the bus layer
  task automatic xfer(input logic w, input logic p, input logic [7:0] c, input logic [15:0] d);
    @(posedge sys_clk_in);
    #1;
    req_out = '{wr: w, rd: !w, page: p, cmd: c, wdata: d};
    @(posedge sys_clk_in);
    #1;
    // released data flips so a stale word can never look valid
    req_out = '{wr: 1'b0, rd: 1'b0, page: !p, cmd: ~c, wdata: ~d};
  endtask
  // two requests on consecutive edges, which the design takes back to back
  task automatic xfer2(input logic w1, input logic p1, input logic [7:0] c1, input logic [15:0] d1,
                       input logic w2, input logic p2, input logic [7:0] c2, input logic [15:0] d2);
    @(posedge sys_clk_in);
    #1;
    req_out = '{wr: w1, rd: !w1, page: p1, cmd: c1, wdata: d1};
    @(posedge sys_clk_in);
    #1;
    req_out = '{wr: w2, rd: !w2, page: p2, cmd: c2, wdata: d2};
    @(posedge sys_clk_in);
    #1;
    req_out = '{wr: 1'b0, rd: 1'b0, page: !p2, cmd: ~c2, wdata: ~d2};
  endtask
endmodule

// File: verif/test_olc_regs.sv
`timescale 1ns/10ps
module test_olc_regs;
  import olc_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  olc_req_t req;
  olc_meas_t [OLC_PAGES-1:0] meas = '0;
  logic [15:0] rdata;
  logic rvalid, cmd_ok;
  logic [OLC_PAGES-1:0][15:0] target, aslope, aov;
  logic [OLC_PAGES-1:0] ovf, uvf, otf;
  int n_fail = 0;
  int num_checks = 0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  olc_host_model host (.sys_clk_in(sys_clk_in), .req_out(req));
  olc_regs dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .req_in(req), .meas_in(meas),
    .rdata_out(rdata), .rvalid_out(rvalid), .cmd_ok_out(cmd_ok), .target_out(target),
    .ov_fault_out(ovf), .uv_fault_out(uvf), .ot_fault_out(otf),
    .active_slope_out(aslope), .active_ov_out(aov));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic p, input logic [7:0] c, input logic [15:0] e, input logic ok);
    host.xfer(1'b0, p, c, 16'h0000);
    chk(rdata, e);
    chk({14'h0000, rvalid, cmd_ok}, {14'h0000, 1'b1, ok});
  endtask
  task automatic wrchk(input logic p, input logic [7:0] c, input logic [15:0] d, input logic ok);
    host.xfer(1'b1, p, c, d);
    chk({15'h0000, cmd_ok}, {15'h0000, ok});
  endtask
  // flags of page 0 as {ov, uv, ot}, checked one edge after the inputs move
  task automatic flt(input olc_meas_t m, input logic [2:0] e, input logic [15:0] t);
    meas[0] = m;
    @(posedge sys_clk_in);
    #1;
    chk({13'h0000, ovf[0], uvf[0], otf[0]}, {13'h0000, e});
    chk(target[0], t);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge sys_clk_in);
    #1;
    reset_in = 1'b0;
    for (int p = 0; p < 2; p++) begin
      rdchk(p[0], OLC_CMD_SLOPE, 16'h0000, 1'b1);
      rdchk(p[0], OLC_CMD_FLOOR, 16'h0000, 1'b1);
      rdchk(p[0], OLC_CMD_OV, 16'h076C, 1'b1);
      rdchk(p[0], OLC_CMD_UV, 16'h0000, 1'b1);
      rdchk(p[0], OLC_CMD_OT, 16'h007D, 1'b1);
    end
    rdchk(1'b0, 8'h2C, 16'h0000, 1'b0);
    wrchk(1'b0, 8'h2C, 16'h1234, 1'b0);
    $display("reset values and unknown commands done");
    wrchk(1'b0, OLC_CMD_OV, 16'h0800, 1'b1);
    chk(aov[0], 16'h076C);
    rdchk(1'b0, OLC_CMD_OV, 16'h0800, 1'b1);
    wrchk(1'b1, OLC_CMD_SLOPE, 16'h0640, 1'b1);
    chk(aslope[1], 16'h0000);
    wrchk(1'b0, OLC_CMD_COMMIT, 16'h0000, 1'b1);
    chk(aov[0], 16'h0800);
    chk(aov[1], 16'h076C);
    chk(aslope[1], 16'h0000);
    wrchk(1'b1, OLC_CMD_COMMIT, 16'h0000, 1'b1);
    chk(aslope[1], 16'h0640);
    chk(aslope[0], 16'h0000);
    host.xfer2(1'b1, 1'b0, OLC_CMD_SLOPE, 16'h0123, 1'b0, 1'b0, OLC_CMD_SLOPE, 16'h0000);
    chk(rdata, 16'h0123);
    chk(aslope[0], 16'h0000);
    host.xfer2(1'b1, 1'b1, OLC_CMD_OV, 16'h0700, 1'b1, 1'b1, OLC_CMD_COMMIT, 16'h0000);
    chk(aov[1], 16'h0700);
    chk(aov[0], 16'h0800);
    $display("commit test done");
    wrchk(1'b0, OLC_CMD_UV, 16'h0500, 1'b1);
    wrchk(1'b0, OLC_CMD_FLOOR, 16'h0300, 1'b1);
    flt('{1'b1, 1'b1, 16'h0801, 16'h007E, 16'h0100}, 3'b101, 16'h0300);
    chk({13'h0000, ovf[1], uvf[1], otf[1]}, 16'h0000);
    flt('{1'b1, 1'b1, 16'h0800, 16'h007D, 16'h0400}, 3'b000, 16'h0400);
    flt('{1'b1, 1'b1, 16'h04FF, 16'h007D, 16'h02FF}, 3'b000, 16'h0300);
    flt('{1'b0, 1'b1, 16'h04FF, 16'h007D, 16'h0300}, 3'b010, 16'h0300);
    flt('{1'b0, 1'b0, 16'h04FF, 16'h007D, 16'h0300}, 3'b000, 16'h0300);
    wrchk(1'b1, OLC_CMD_FLOOR, 16'h0200, 1'b1);
    wrchk(1'b1, OLC_CMD_OT, OLC_OT_MAX, 1'b1);
    rdchk(1'b1, OLC_CMD_OT, 16'h07D0, 1'b1);
    rdchk(1'b0, OLC_CMD_OT, 16'h007D, 1'b1);
    chk(target[1], 16'h0200);
    $display("fault and floor test done");
    end_of_test();
  end
endmodule
